// ---- rtl/ata_pwr_consts.vh ----
// constants for the power, dma and monitoring command block
`ifndef ATA_PWR_CONSTS_VH
`define ATA_PWR_CONSTS_VH
// opcodes
`define OP_SLEEP_A      8'h99
`define OP_SLEEP_B      8'hE6
`define OP_STBY_A       8'h96
`define OP_STBY_B       8'hE2
`define OP_STBYI_A      8'h94
`define OP_STBYI_B      8'hE0
`define OP_IDLE_A       8'h97
`define OP_IDLE_B       8'hE3
`define OP_IDLEI_A      8'h95
`define OP_IDLEI_B      8'hE1
`define OP_RDMA_A       8'hC8
`define OP_RDMA_B       8'hC9
`define OP_WDMA_A       8'hCA
`define OP_WDMA_B       8'hCB
`define OP_MON          8'hB0
// monitoring subcommands and signature
`define MON_CYL_LO      8'h4F
`define MON_CYL_HI      8'hC2
`define MON_BAD_LO      8'hF4
`define MON_BAD_HI      8'h2C
`define MON_F_ENABLE    8'hD8
`define MON_F_DISABLE   8'hD9
`define MON_F_STATUS    8'hDA
`define MON_F_AUTOSAVE  8'hD2
`define MON_F_SAVE      8'hD3
`define MON_F_OFFLINE   8'hDB
`define MON_F_OFFL_IMM  8'hD4
`define MON_F_RDLOG     8'hD5
`define MON_F_WRLOG     8'hD6
`define AUTOSAVE_ON     8'hF1
`define AUTOSAVE_OFF    8'h00
// identify word 82 feature bit
`define ID82_MON_BIT    0
// standby timer decode, in 5 s ticks
`define TMR_MAX_LIN     8'hF0
`define TMR_21M         8'hFC
`define TMR_30M_ALT     8'hFD
`define TICKS_30M       12'h168
`define TICKS_21M       12'h0FC
`define TICKS_21M15     12'h0FF
// timing
`define CLK_HZ          50000000
`define TICK_SEC        5
`define TICK_CYCLES     (`CLK_HZ * `TICK_SEC)
// error logs
`define LOG_SUMMARY     5
`define LOG_FULL        255
`endif

// ---- rtl/stby_timer_decode.v ----
// standby timer setting decode to count of five-second ticks
`timescale 1ns/1ps
`include "ata_pwr_consts.vh"
module stby_timer_decode (
  input  wire [7:0]  sector_count_value, // setting from the host
  output reg  [11:0] ticks               // zero means disabled
);
  // the lower range is linear, the top of the byte is a few fixed periods
  always @* begin
    if (sector_count_value <= `TMR_MAX_LIN)
      ticks = {4'h0, sector_count_value};
    else if (sector_count_value == `TMR_21M)
      ticks = `TICKS_21M;
    else if (sector_count_value > `TMR_30M_ALT)
      ticks = `TICKS_21M15;
    else
      ticks = `TICKS_30M;
  end
endmodule

// ---- rtl/err_log_counter.v ----
// counters of logged errors for the summary and comprehensive logs
`timescale 1ns/1ps
`include "ata_pwr_consts.vh"
module err_log_counter (
  input  wire       mclk,      // clock
  input  wire       nrst,      // async reset, active low
  input  wire       err_evt,   // one error reported
  input  wire       log_en,    // logging allowed now
  output reg  [2:0] sum_cnt_q, // summary entries held
  output reg  [7:0] full_cnt_q // comprehensive entries held
);
  // both logs saturate; once a count is full, further errors are not counted
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sum_cnt_q  <= 3'h0;
      full_cnt_q <= 8'h00;
    end else if (err_evt && log_en) begin
      if (sum_cnt_q != `LOG_SUMMARY)
        sum_cnt_q <= sum_cnt_q + 3'h1;
      if (full_cnt_q != `LOG_FULL)
        full_cnt_q <= full_cnt_q + 8'h01;
    end
  end
endmodule

// ---- rtl/ata_pwr_cmd.v ----
// command handling for power, slave dma and reliability monitoring
//
// Contract
// - sleep: spin down, then clear busy, interrupt
// - leave sleep only through any reset
// - standby loads timer from sector count
// - timer setting decode to five-second ticks
// - timer disabled after power-on
// - standby immediate: interrupt may precede stop
// - raise dmarq only when ready
// - one interrupt per dma command
// - status read clears intrq
// - read dma error keeps failing address
// - write dma error keeps failing address
// - monitor subcommands decoded by features value
// - identify word 82 bit 0 set
// - any value at or below threshold flags
// - summary five, comprehensive 255 error entries
// - no error logging in standby or sleep
// - disabling monitor blocks only log reads; here every subcommand but enable aborts while disabled
// - save attributes on idle-imm, stby-imm, sleep
// - save attributes before timer standby entry
// - monitoring disabled from factory and reset
// - timer expiry moves device into standby
// - bad signature or feature aborts command
`timescale 1ns/1ps
`include "ata_pwr_consts.vh"
module ata_pwr_cmd #(
  parameter TICK_CYC = `TICK_CYCLES      // cycles per five-second tick
) (
  input  wire        mclk,               // 50 MHz clock
  input  wire        nrst,               // async reset, active low
  input  wire        soft_rst,           // software reset from host, pulse
  input  wire        cmd_wr,             // command register written, pulse
  input  wire [7:0]  cmd_code,           // opcode
  input  wire [7:0]  features,           // features register
  input  wire [7:0]  sector_count_value, // sector count register
  input  wire [7:0]  cyl_lo_in,          // cylinder low register
  input  wire [7:0]  cyl_hi_in,          // cylinder high register
  input  wire        status_rd,          // status register read, pulse
  input  wire        spin_stopped,       // spindle at rest, pin level
  input  wire        media_ready,        // data path ready for dma, pin
  input  wire        xfer_done,          // last sector moved, pulse
  input  wire        xfer_err,           // sector failed, pulse
  input  wire [7:0]  err_sector,         // failing sector number
  input  wire [7:0]  err_cyl_lo,         // failing cylinder low
  input  wire [7:0]  err_cyl_hi,         // failing cylinder high
  input  wire [3:0]  err_head,           // failing head
  input  wire        attr_fail,          // some attribute at or below limit
  input  wire        save_done,          // attribute save finished, pulse
  output reg         busy_q,             // busy status bit
  output reg         intrq_q,            // interrupt request
  output reg         dmarq_q,            // dma request
  output reg         abort_q,            // aborted command error
  output reg         spin_down_q,        // spindle stop request
  output reg         iface_off_q,        // interface inactive in sleep
  output reg         standby_q,          // in standby
  output reg         sleep_q,            // in sleep
  output reg         attr_save_q,        // attribute save request, pulse
  output reg         mon_en_q,           // monitoring enabled
  output reg         autosave_q,         // attribute autosave enabled
  output reg         log_rd_ok_q,        // log read delivered
  output reg         id82_mon_q,         // identify word 82 bit 0
  output reg [7:0]   tf_sector_q,        // sector number returned
  output reg [7:0]   tf_cyl_lo_q,        // cylinder low returned
  output reg [7:0]   tf_cyl_hi_q,        // cylinder high returned
  output reg [3:0]   tf_head_q,          // head returned
  output reg [2:0]   sum_cnt_q,          // summary log entries
  output reg [7:0]   full_cnt_q          // comprehensive log entries
);
  // sequencer states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SPIN  = 3'h1;
  localparam [2:0] ST_DMA   = 3'h2;
  localparam [2:0] ST_SAVE  = 3'h3;
  localparam [2:0] ST_SLEEP = 3'h4;

  // opcode pair match, used for every two-code command
  function is_op;
    input [7:0] c;
    input [7:0] a;
    input [7:0] b;
    begin
      is_op = (c == a) || (c == b);
    end
  endfunction

  // two-flop synchronisers for pin levels; only the second stage is read
  wire [2:0] pin_raw = {attr_fail, media_ready, spin_stopped};
  wire [2:0] pin_s;
  genvar     g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      reg [1:0] sync_q;
      always @(posedge mclk or negedge nrst) begin
        if (!nrst)
          sync_q <= 2'h0;
        else
          sync_q <= {sync_q[0], pin_raw[g]};
      end
      assign pin_s[g] = sync_q[1];
    end
  endgenerate
  wire       stop_s = pin_s[0];
  wire       rdy_s  = pin_s[1];
  wire       fail_s = pin_s[2];

  // command decode
  wire op_sleep = is_op(cmd_code, `OP_SLEEP_A, `OP_SLEEP_B);
  wire op_stby  = is_op(cmd_code, `OP_STBY_A, `OP_STBY_B);
  wire op_stbyi = is_op(cmd_code, `OP_STBYI_A, `OP_STBYI_B);
  wire op_idle  = is_op(cmd_code, `OP_IDLE_A, `OP_IDLE_B);
  wire op_idlei = is_op(cmd_code, `OP_IDLEI_A, `OP_IDLEI_B);
  wire op_rdma  = is_op(cmd_code, `OP_RDMA_A, `OP_RDMA_B);
  wire op_wdma  = is_op(cmd_code, `OP_WDMA_A, `OP_WDMA_B);
  wire op_mon   = (cmd_code == `OP_MON);
  wire sig_ok   = (cyl_lo_in == `MON_CYL_LO) && (cyl_hi_in == `MON_CYL_HI);
  // subcommands known here; anything else is aborted
  wire f_known  = (features == `MON_F_ENABLE) || (features == `MON_F_DISABLE) ||
                  (features == `MON_F_STATUS) || (features == `MON_F_AUTOSAVE) ||
                  (features == `MON_F_SAVE) || (features == `MON_F_OFFLINE) ||
                  (features == `MON_F_OFFL_IMM) || (features == `MON_F_RDLOG) ||
                  (features == `MON_F_WRLOG);

  // sequencer state, pending timed standby and the timer itself
  reg  [2:0]  st_q;
  reg         dma_wr_q;
  reg         save_then_stby_q;
  reg  [11:0] tmr_set_q;
  reg  [11:0] tmr_cnt_q;
  reg  [27:0] pre_q;
  wire [11:0] dec_ticks;

  // sleep accepts nothing but a reset
  wire accept = cmd_wr && !busy_q && (st_q != ST_SLEEP);

  // decode is shared by the standby and idle commands
  stby_timer_decode u_dec (
    .sector_count_value (sector_count_value),
    .ticks              (dec_ticks)
  );

  // errors are reported on failed dma sectors; logging paused at low power
  err_log_counter u_log (
    .mclk       (mclk),
    .nrst       (nrst),
    .err_evt    (xfer_err && (st_q == ST_DMA)),
    .log_en     (!standby_q && !sleep_q),
    .sum_cnt_q  (sum_cnt_q),
    .full_cnt_q (full_cnt_q)
  );

  // prescaler and standby countdown, restarted by every accepted command
  wire tick    = (pre_q == TICK_CYC - 1);
  // expiry waits for an idle sequencer so a running command always wins
  wire tmr_exp = (tmr_set_q != 12'h000) && (tmr_cnt_q == 12'h000) && !standby_q &&
                 (st_q == ST_IDLE) && !cmd_wr;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre_q     <= 28'h0000000;
      tmr_set_q <= 12'h000;
      tmr_cnt_q <= 12'h000;
    end else if (accept) begin
      pre_q <= 28'h0000000;
      if (op_stby || op_idle) begin
        tmr_set_q <= dec_ticks;
        tmr_cnt_q <= dec_ticks;
      end else begin
        tmr_cnt_q <= tmr_set_q;
      end
    end else begin
      pre_q <= tick ? 28'h0000000 : pre_q + 28'h0000001;
      if (tick && tmr_cnt_q != 12'h000)
        tmr_cnt_q <= tmr_cnt_q - 12'h001;
    end
  end

  // main command sequencer
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q             <= ST_IDLE;
      busy_q           <= 1'b0;
      intrq_q          <= 1'b0;
      dmarq_q          <= 1'b0;
      abort_q          <= 1'b0;
      spin_down_q      <= 1'b0;
      iface_off_q      <= 1'b0;
      standby_q        <= 1'b0;
      sleep_q          <= 1'b0;
      attr_save_q      <= 1'b0;
      mon_en_q         <= 1'b0;
      autosave_q       <= 1'b0;
      log_rd_ok_q      <= 1'b0;
      id82_mon_q       <= 1'b0;
      dma_wr_q         <= 1'b0;
      save_then_stby_q <= 1'b0;
      tf_sector_q      <= 8'h00;
      tf_cyl_lo_q      <= 8'h00;
      tf_cyl_hi_q      <= 8'h00;
      tf_head_q        <= 4'h0;
    end else if (soft_rst) begin
      // software reset also wakes from sleep; monitor state is kept
      st_q        <= ST_IDLE;
      busy_q      <= 1'b0;
      intrq_q     <= 1'b0;
      dmarq_q     <= 1'b0;
      abort_q     <= 1'b0;
      spin_down_q <= 1'b0;
      iface_off_q <= 1'b0;
      sleep_q     <= 1'b0;
      standby_q   <= 1'b0;
      attr_save_q <= 1'b0;
    end else begin
      id82_mon_q  <= 1'b1;
      attr_save_q <= 1'b0;
      log_rd_ok_q <= 1'b0;
      // status read lowers the interrupt; a new raise this cycle wins
      if (status_rd)
        intrq_q <= 1'b0;
      case (st_q)
        ST_IDLE, ST_SAVE: begin
          if (accept) begin
            // a command during the save cancels the timed standby and still runs
            st_q             <= ST_IDLE;
            save_then_stby_q <= 1'b0;
            abort_q          <= 1'b0;
            if (op_sleep || op_stbyi) begin
              busy_q      <= 1'b1;
              spin_down_q <= 1'b1;
              attr_save_q <= mon_en_q;
              st_q        <= op_sleep ? ST_SPIN : ST_IDLE;
              if (op_stbyi) begin
                standby_q <= 1'b1;
                busy_q    <= 1'b0;
                intrq_q   <= 1'b1;
              end else begin
                sleep_q <= 1'b1;
              end
            end else if (op_stby) begin
              // the timer was loaded from the same count by the timer process
              spin_down_q <= 1'b1;
              standby_q   <= 1'b1;
              intrq_q     <= 1'b1;
            end else if (op_idle || op_idlei) begin
              spin_down_q <= 1'b0;
              standby_q   <= 1'b0;
              attr_save_q <= op_idlei && mon_en_q;
              intrq_q     <= 1'b1;
            end else if (op_rdma || op_wdma) begin
              // busy stays up through the data phase, where the task file is invalid
              busy_q      <= 1'b1;
              dma_wr_q    <= op_wdma;
              spin_down_q <= 1'b0;
              standby_q   <= 1'b0;
              st_q        <= ST_DMA;
            end else if (op_mon) begin
              intrq_q <= 1'b1;
              if (!sig_ok || !f_known) begin
                abort_q <= 1'b1;
              end else if (features == `MON_F_ENABLE) begin
                mon_en_q <= 1'b1;
              end else if (features == `MON_F_RDLOG) begin
                // log keeps filling while off; only delivery is blocked
                log_rd_ok_q <= mon_en_q;
                abort_q     <= !mon_en_q;
              end else if (!mon_en_q) begin
                abort_q <= 1'b1;
              end else if (features == `MON_F_DISABLE) begin
                mon_en_q <= 1'b0;
              end else if (features == `MON_F_STATUS) begin
                attr_save_q <= 1'b1;
                tf_cyl_lo_q <= fail_s ? `MON_BAD_LO : `MON_CYL_LO;
                tf_cyl_hi_q <= fail_s ? `MON_BAD_HI : `MON_CYL_HI;
              end else if (features == `MON_F_AUTOSAVE) begin
                if (sector_count_value == `AUTOSAVE_ON)
                  autosave_q <= 1'b1;
                else if (sector_count_value == `AUTOSAVE_OFF)
                  autosave_q <= 1'b0;
                else
                  abort_q <= 1'b1;
              end else if (features == `MON_F_SAVE) begin
                attr_save_q <= 1'b1;
              end
            end else begin
              intrq_q <= 1'b1;
            end
          end else if (st_q == ST_SAVE) begin
            // standby only once the attributes are safely stored
            // limitation: a save that never reports done postpones standby
            if (save_done) begin
              standby_q        <= save_then_stby_q;
              spin_down_q      <= save_then_stby_q;
              save_then_stby_q <= 1'b0;
              st_q             <= ST_IDLE;
            end
          end else if (tmr_exp) begin
            // save ahead of the timed spin down; standby follows save_done
            attr_save_q      <= 1'b1;
            save_then_stby_q <= 1'b1;
            st_q             <= ST_SAVE;
          end
        end
        ST_SPIN: begin
          // sleep: completion only once rotation has stopped
          if (stop_s) begin
            busy_q      <= 1'b0;
            intrq_q     <= 1'b1;
            iface_off_q <= 1'b1;
            st_q        <= ST_SLEEP;
          end
        end
        ST_DMA: begin
          // request tracks the synced ready; the host moves data only under it
          dmarq_q <= rdy_s;
          if (xfer_err) begin
            // hold where the failing sector sits, stop there
            tf_sector_q <= err_sector;
            tf_cyl_lo_q <= err_cyl_lo;
            tf_cyl_hi_q <= err_cyl_hi;
            tf_head_q   <= err_head;
            abort_q     <= 1'b1;
          end
          // one interrupt per command, clean end or failure alike
          if (xfer_err || xfer_done) begin
            dmarq_q <= 1'b0;
            busy_q  <= 1'b0;
            intrq_q <= 1'b1;
            st_q    <= ST_IDLE;
          end
        end
        ST_SLEEP: begin
          // only a reset leaves here
          st_q <= ST_SLEEP;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ---- verif/ata_pwr_cmd_sva.sv ----
// port assertions for the power, dma and monitoring command block
`timescale 1ns/1ps
module ata_pwr_cmd_chk (
  input wire       mclk, nrst, soft_rst, cmd_wr, status_rd, spin_stopped,
  input wire       xfer_done, xfer_err, busy_q, intrq_q, dmarq_q, abort_q,
  input wire       iface_off_q, standby_q, sleep_q, attr_save_q, mon_en_q, log_rd_ok_q,
  input wire [7:0] cmd_code, cyl_lo_in, err_sector, tf_sector_q, full_cnt_q,
  input wire [3:0] err_head, tf_head_q,
  input wire [2:0] sum_cnt_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // a command is only taken when idle and awake
  wire take = cmd_wr && !busy_q && !sleep_q;

  a_sleep_holds: assert property (sleep_q && !soft_rst |=> sleep_q)
    else $error("sleep left without a reset");
  a_soft_wake: assert property (soft_rst |=> !sleep_q)
    else $error("soft reset did not end sleep");
  a_sleep_done: assert property ($rose(spin_stopped) && sleep_q |->
    ##[1:4] (!busy_q && intrq_q && iface_off_q))
    else $error("sleep completion missing");
  a_stby_take: assert property (take && (cmd_code == 8'h96 || cmd_code == 8'hE2)
    |=> standby_q && intrq_q)
    else $error("standby not entered");
  a_dma_gate: assert property (dmarq_q |-> busy_q)
    else $error("dma request outside a command");
  a_dma_done: assert property (xfer_done && dmarq_q |=> intrq_q && !busy_q && !dmarq_q)
    else $error("dma completion wrong");
  a_err_addr: assert property (xfer_err && dmarq_q |=> abort_q &&
    tf_sector_q == $past(err_sector) && tf_head_q == $past(err_head))
    else $error("failing address not kept");
  a_intr_clear: assert property (status_rd && !busy_q && !cmd_wr |=> !intrq_q)
    else $error("status read left interrupt up");
  a_save_on: assert property (take && mon_en_q &&
    (cmd_code inside {8'h99, 8'hE6, 8'h94, 8'hE0, 8'h95, 8'hE1}) |-> ##[1:2] attr_save_q)
    else $error("attribute save missing");
  a_mon_sig: assert property (take && cmd_code == 8'hB0 && cyl_lo_in != 8'h4F
    |=> abort_q && intrq_q)
    else $error("bad signature not aborted");
  a_log_rd: assert property ($rose(log_rd_ok_q) |-> $past(mon_en_q))
    else $error("log read while disabled");
  a_log_hold: assert property (standby_q || sleep_q |=> $stable(full_cnt_q))
    else $error("error logged in low power");
  a_log_cap: assert property (sum_cnt_q <= 3'h5 && full_cnt_q >= {5'h00, sum_cnt_q})
    else $error("log counts out of range");
endmodule
bind ata_pwr_cmd ata_pwr_cmd_chk u_chk (.*);

// ---- verif/dma_host_model.sv ----
// host dma channel and drive mechanics around the command block
`timescale 1ns/1ps
module dma_host_model (
  input  wire       mclk,         // clock
  input  wire       nrst,         // async reset, active low
  input  wire       busy_q,       // command running
  input  wire       dmarq_q,      // dma request
  input  wire       spin_down_q,  // spindle stop request
  input  wire       attr_save_q,  // save request
  input  wire       xfer_fail,    // make this transfer fail
  output reg        media_ready,  // data path ready
  output reg        xfer_done,    // transfer finished
  output reg        xfer_err,     // transfer failed
  output reg        spin_stopped, // spindle at rest
  output reg        save_done,    // save finished
  output wire [7:0] err_sector,   // failing sector
  output wire [7:0] err_cyl_lo,   // failing cylinder low
  output wire [7:0] err_cyl_hi,   // failing cylinder high
  output wire [3:0] err_head      // failing head
);
  reg [3:0] cnt_q;
  reg [2:0] spin_q;
  reg       slow_q;
  reg       sv_q;
  // every other transfer is slow; the end comes at a fixed count
  wire      fin = dmarq_q && cnt_q == (slow_q ? 4'h7 : 4'h1);
  // address lines carry junk unless an error is reported
  assign err_sector = xfer_err ? 8'h3C : 8'hC3;
  assign err_cyl_lo = xfer_err ? 8'h12 : 8'hED;
  assign err_cyl_hi = xfer_err ? 8'h34 : 8'hCB;
  assign err_head   = xfer_err ? 4'h5 : 4'hA;
  // mechanics and transfer sequencing
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {cnt_q, spin_q, slow_q, sv_q} <= 10'h000;
      {media_ready, xfer_done, xfer_err, spin_stopped, save_done} <= 5'h00;
    end else begin
      media_ready <= busy_q;
      spin_q <= {spin_q[1:0], spin_down_q};
      spin_stopped <= spin_q[2];
      sv_q <= attr_save_q;
      save_done <= sv_q;
      cnt_q <= dmarq_q ? cnt_q + 4'h1 : 4'h0; // data moves only under request
      xfer_done <= fin && !xfer_fail;
      xfer_err <= fin && xfer_fail;
      if (fin) begin
        slow_q <= ~slow_q;
      end
    end
  end
endmodule

// ---- verif/ata_pwr_cmd_test.sv ----
// self-checking bench for the power, dma and monitoring command block
`timescale 1ns/1ps
module ata_pwr_cmd_test;
  localparam TC = 4;
  localparam [47:0] SCL = 48'h01F0F1FCFDFE;
  reg mclk = 0, nrst = 0, soft_rst = 0, cmd_wr = 0, status_rd = 0, attr_fail = 0, xfer_fail = 0;
  reg [7:0] cmd_code = 0, features = 0, sector_count_value = 0, cyl_lo_in = 8'h4F;
  reg [7:0] cyl_hi_in = 8'hC2, saves = 0, s0;
  wire busy_q, intrq_q, dmarq_q, abort_q, spin_down_q, iface_off_q, standby_q, sleep_q;
  wire attr_save_q, mon_en_q, autosave_q, log_rd_ok_q, id82_mon_q, save_done;
  wire spin_stopped, media_ready, xfer_done, xfer_err;
  wire [7:0] tf_sector_q, tf_cyl_lo_q, tf_cyl_hi_q, full_cnt_q, err_sector, err_cyl_lo, err_cyl_hi;
  wire [3:0] tf_head_q, err_head;
  wire [2:0] sum_cnt_q;
  integer err_count = 0, check_count = 0, cyc = 0, i, k;

  ata_pwr_cmd #(.TICK_CYC(TC)) u_dut (.*);
  dma_host_model u_host (.*);

  always #10 mclk = ~mclk;
  // cycle ceiling and save request tally
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (attr_save_q === 1'b1) saves <= saves + 8'h01;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      complete_run;
    end
  end

  task complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input [7:0] got, input [7:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  // opcode, features and sector count settle with the command strobe; cylinder values are driven apart
  task cmd(input [7:0] op, input [7:0] ft, input [7:0] sc);
    @(negedge mclk); // an edge between strobes, never a drop and rise at once
    cmd_code = op;
    features = ft;
    sector_count_value = sc;
    cmd_wr = 1;
    @(negedge mclk) cmd_wr = 0;
  endtask
  task srd;
    status_rd = 1;
    @(negedge mclk) status_rd = 0;
  endtask
  task wt(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  // bounded waits on completion and standby
  task wint;
    for (k = 0; k < 300 && intrq_q !== 1'b1; k = k + 1) @(negedge mclk);
  endtask
  task wstby;
    for (k = 0; k < 30 && standby_q !== 1'b1; k = k + 1) @(negedge mclk);
  endtask
  function integer ticks_of(input [7:0] s);
    if (s <= 8'hF0) ticks_of = s;
    else if (s == 8'hFC) ticks_of = 252;
    else if (s >= 8'hFE) ticks_of = 255;
    else ticks_of = 360;
  endfunction

  initial begin
    wt(20);
    nrst = 1;
    @(negedge mclk);
    chk("id82", id82_mon_q, 1'h1);
    chk("mon_default", mon_en_q, 1'h0);
    wt(40);
    chk("timer_off", standby_q, 1'h0);
    cmd(8'h96, 8'h00, 8'h00);
    chk("standby", standby_q, 1'h1);
    srd;
    chk("intrq_clear", intrq_q, 1'h0);
    // monitoring subcommands and refusals
    cyl_lo_in = 8'h00;
    cmd(8'hB0, 8'hD8, 8'h00);
    chk("sig_abort", abort_q, 1'h1);
    cyl_lo_in = 8'h4F;
    cmd(8'hB0, 8'hD8, 8'h00);
    chk("mon_on", mon_en_q, 1'h1);
    cmd(8'hB0, 8'hD5, 8'h00);
    chk("log_read", log_rd_ok_q, 1'h1);
    cmd(8'hB0, 8'hD2, 8'hF1);
    chk("autosave", autosave_q, 1'h1);
    cmd(8'hB0, 8'hD2, 8'h07);
    chk("autosave_bad", abort_q, 1'h1);
    attr_fail = 1;
    wt(4);
    cmd(8'hB0, 8'hDA, 8'h00);
    chk("fail_lo", tf_cyl_lo_q, 8'hF4);
    chk("fail_hi", tf_cyl_hi_q, 8'h2C);
    attr_fail = 0;
    wt(4);
    cmd(8'hB0, 8'hDA, 8'h00);
    chk("good_lo", tf_cyl_lo_q, 8'h4F);
    cmd(8'hB0, 8'hD3, 8'h00);
    chk("save_cmd", attr_save_q, 1'h1);
    cmd(8'hB0, 8'hD9, 8'h00);
    chk("mon_off", mon_en_q, 1'h0);
    cmd(8'hB0, 8'hD5, 8'h00);
    chk("log_blocked", log_rd_ok_q, 1'h0);
    chk("log_abort", abort_q, 1'h1);
    cmd(8'hB0, 8'hD8, 8'h00);
    srd;
    // dma: one good read, then failing writes and reads
    for (i = 0; i < 7; i = i + 1) begin
      xfer_fail = (i > 0);
      cmd(8'hC8 | {6'h00, i[1:0]}, 8'h00, 8'h01);
      wint; // task file left alone through the data phase
      chk("dma_busy", busy_q, 1'h0);
      chk("dma_req_off", dmarq_q, 1'h0);
      chk("dma_abort", abort_q, xfer_fail);
      if (xfer_fail) chk("err_sector", tf_sector_q, 8'h3C);
      if (xfer_fail) chk("err_cyl", tf_cyl_hi_q, 8'h34);
      if (xfer_fail) chk("err_head", tf_head_q, 8'h05);
      srd;
      wt(6);
      chk("one_intr", intrq_q, 1'h0);
    end
    chk("sum_log", sum_cnt_q, 3'h5);
    chk("full_log", full_cnt_q, 8'h06);
    // any accepted command restarts the timer
    cmd(8'hE3, 8'h00, 8'h02);
    srd;
    wt(4);
    cmd(8'hB0, 8'hDA, 8'h00);
    srd;
    wt(6);
    chk("restart", standby_q, 1'h0);
    wstby;
    // timer setting decode, with a save before each timed entry
    for (i = 0; i < 6; i = i + 1) begin
      cmd(i[0] ? 8'h97 : 8'hE3, 8'h00, SCL[47 - 8 * i -: 8]);
      srd;
      s0 = saves;
      wt(ticks_of(SCL[47 - 8 * i -: 8]) * TC - 6);
      chk("early", standby_q, 1'h0);
      wstby;
      chk("late", standby_q, 1'h1);
      chk("timed_save", saves - s0, 8'h01);
    end
    cmd(8'h94, 8'h00, 8'h00);
    chk("imm_intr", intrq_q, 1'h1);
    chk("imm_spin", spin_down_q, 1'h1);
    srd;
    // spin back up so the sleep below sees the spindle stop afresh
    cmd(8'hE3, 8'h00, 8'h00);
    srd;
    wt(1100);
    chk("zero_off", standby_q, 1'h0);
    cmd(8'h95, 8'h00, 8'h00);
    chk("idlei_save", attr_save_q, 1'h1);
    srd;
    // sleep, ignored command, software reset
    cmd(8'h99, 8'h00, 8'h00);
    chk("sleep_save", attr_save_q, 1'h1);
    wint;
    chk("sleep_busy", busy_q, 1'h0);
    chk("sleep_iface", iface_off_q, 1'h1);
    srd;
    cmd(8'h96, 8'h00, 8'h00);
    chk("sleep_ignore", intrq_q, 1'h0);
    chk("still_asleep", sleep_q, 1'h1);
    soft_rst = 1;
    @(negedge mclk) soft_rst = 0;
    chk("woken", sleep_q, 1'h0);
    complete_run;
  end
endmodule
